/* File: rtl/csi2_tx_cal_pkg.sv */
package csi2_tx_cal_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] PORT_SEL_OFS = 8'h32;
  localparam logic [7:0] CAL_CTRL_OFS = 8'h34;
  localparam logic [7:0] STATUS_OFS = 8'h35;
  localparam logic [7:0] PORT_SEL_RST = 8'h00;
  localparam logic [7:0] CAL_CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // field positions
  localparam int READ_PORT_BIT = 4;
  localparam int WRITE_PORT1_BIT = 1;
  localparam int WRITE_PORT0_BIT = 0;
  localparam int LEN_LSB = 4;
  localparam int LEN_MSB = 5;
  localparam int PASS_MODE_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int SINGLE_BIT = 1;
  localparam int PERIODIC_BIT = 0;
  localparam int STS_PORT_NUM_BIT = 4;
  localparam int STS_SYNC_BIT = 1;
  localparam int STS_PASS_BIT = 0;

  localparam int NUM_TX = 2;
  localparam int NUM_RX = 4;

  // ************************************************************
  // calibration lengths, in bits
  // ************************************************************
  localparam logic [15:0] CAL_BITS_1K = 16'h0400;
  localparam logic [15:0] CAL_BITS_4K = 16'h1000;
  localparam logic [15:0] CAL_BITS_16K = 16'h4000;
  localparam logic [15:0] CAL_BITS_32K = 16'h8000;

  typedef enum logic [1:0] {
    CAL_LEN_1K = 2'b00,
    CAL_LEN_4K = 2'b01,
    CAL_LEN_16K = 2'b10,
    CAL_LEN_32K = 2'b11
  } cal_len_t;

  // layout matches the control register bit for bit
  typedef struct packed {
    logic [1:0] rsvd;
    cal_len_t cal_length_sel;
    logic pass_mode;
    logic cal_pattern_invert;
    logic single;
    logic periodic;
  } cal_ctrl_t;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic port_num;
    logic [1:0] rsvd_lo;
    logic synced;
    logic pass;
  } status_t;

  // per transmit port view of the packet engine and forwarding logic
  typedef struct packed {
    logic link_idle;
    logic frame_end_sent;
    logic sync_enable;
    logic sync_locked;
    logic tx_error;
  } link_in_t;

  function automatic logic [15:0] cal_bit_count(input cal_len_t len);
    case (len)
      CAL_LEN_1K: cal_bit_count = CAL_BITS_1K;
      CAL_LEN_4K: cal_bit_count = CAL_BITS_4K;
      CAL_LEN_16K: cal_bit_count = CAL_BITS_16K;
      CAL_LEN_32K: cal_bit_count = CAL_BITS_32K;
      default: cal_bit_count = CAL_BITS_1K;
    endcase
  endfunction

endpackage

/* File: rtl/cal_pattern_gen.sv */
`timescale 1ns/1ps
module cal_pattern_gen (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic start,
  input wire logic invert,
  input wire csi2_tx_cal_pkg::cal_len_t len,
  output logic busy,
  output logic cal_data,
  output logic done
);

  typedef enum logic {
    GEN_IDLE = 1'b0,
    GEN_SEND = 1'b1
  } gen_state_t;

  gen_state_t state_q;
  logic [15:0] left_q;

  assign busy = (state_q == GEN_SEND);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= GEN_IDLE;
      left_q <= 16'h0000;
      cal_data <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (state_q)
        GEN_IDLE: begin
          if (start) begin
            // first bit is 0, or 1 when inverted
            cal_data <= invert;
            left_q <= csi2_tx_cal_pkg::cal_bit_count(len) - 16'h0001;
            state_q <= GEN_SEND;
          end
        end
        GEN_SEND: begin
          if (left_q == 16'h0000) begin
            state_q <= GEN_IDLE;
            done <= 1'b1;
          end else begin
            cal_data <= ~cal_data;
            left_q <= left_q - 16'h0001;
          end
        end
        default: state_q <= GEN_IDLE;
      endcase
    end
  end

endmodule

/* File: rtl/pass_tracker.sv */
`timescale 1ns/1ps
module pass_tracker #(
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic pass_mode,
  input wire logic [NUM_RX-1:0] rx_enable_mask,
  input wire logic [NUM_RX-1:0] rx_video_valid,
  input wire logic sync_enable,
  input wire logic sync_locked,
  input wire logic tx_error,
  output logic pass_q,
  output logic synced_q
);

  logic any_ok;
  logic all_ok;
  logic data_ok;

  assign any_ok = |(rx_enable_mask & rx_video_valid);
  // with no port enabled the all-ports mode reports no pass
  assign all_ok = (|rx_enable_mask) &&
                  ((rx_enable_mask & rx_video_valid) == rx_enable_mask);
  assign data_ok = pass_mode ? all_ok : any_ok;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pass_q <= 1'b0;
    end else if (clk_en) begin
      if (sync_enable) begin
        // only availability: delivery may still be held for alignment
        pass_q <= data_ok;
      end else if (tx_error) begin
        pass_q <= 1'b0;
      end else begin
        pass_q <= data_ok;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      synced_q <= 1'b0;
    end else if (clk_en) begin
      synced_q <= sync_enable && sync_locked;
    end
  end

endmodule

/* File: rtl/csi2_tx_skew_cal_and_status.sv */
`timescale 1ns/1ps
module csi2_tx_skew_cal_and_status #(
  parameter int NUM_TX = csi2_tx_cal_pkg::NUM_TX,
  parameter int NUM_RX = csi2_tx_cal_pkg::NUM_RX
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_RX-1:0] rx_video_valid,
  input wire logic [NUM_TX-1:0][NUM_RX-1:0] rx_enable_mask,
  input wire csi2_tx_cal_pkg::link_in_t [NUM_TX-1:0] link_in,
  output logic [NUM_TX-1:0] cal_active,
  output logic [NUM_TX-1:0] cal_data,
  output logic [NUM_TX-1:0] tx_pass,
  output logic [NUM_TX-1:0] tx_synced
);

  // ************************************************************
  // decode
  // ************************************************************
  logic [7:0] port_sel_q;
  logic read_port;
  logic [1:0] write_port_en;
  logic wr_port_sel;
  logic wr_cal_ctrl;
  logic rd_hit;

  assign read_port = port_sel_q[csi2_tx_cal_pkg::READ_PORT_BIT];
  assign write_port_en = {port_sel_q[csi2_tx_cal_pkg::WRITE_PORT1_BIT],
                          port_sel_q[csi2_tx_cal_pkg::WRITE_PORT0_BIT]};
  assign wr_port_sel = reg_wr && (reg_addr == csi2_tx_cal_pkg::PORT_SEL_OFS);
  assign wr_cal_ctrl = reg_wr && (reg_addr == csi2_tx_cal_pkg::CAL_CTRL_OFS);
  assign rd_hit = (reg_addr == csi2_tx_cal_pkg::PORT_SEL_OFS) ||
                  (reg_addr == csi2_tx_cal_pkg::CAL_CTRL_OFS) ||
                  (reg_addr == csi2_tx_cal_pkg::STATUS_OFS);

  // ************************************************************
  // port select register
  // ************************************************************
  // only the read select and the two write enables are storage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_sel_q <= csi2_tx_cal_pkg::PORT_SEL_RST;
    end else if (clk_en && wr_port_sel) begin
      port_sel_q <= 8'h00;
      port_sel_q[csi2_tx_cal_pkg::READ_PORT_BIT] <=
        reg_wdata[csi2_tx_cal_pkg::READ_PORT_BIT];
      port_sel_q[csi2_tx_cal_pkg::WRITE_PORT1_BIT] <=
        reg_wdata[csi2_tx_cal_pkg::WRITE_PORT1_BIT];
      port_sel_q[csi2_tx_cal_pkg::WRITE_PORT0_BIT] <=
        reg_wdata[csi2_tx_cal_pkg::WRITE_PORT0_BIT];
    end
  end

  // ************************************************************
  // per transmit port bank
  // ************************************************************
  csi2_tx_cal_pkg::cal_ctrl_t [NUM_TX-1:0] cal_ctrl_q;
  csi2_tx_cal_pkg::status_t [NUM_TX-1:0] status_w;

  genvar p;
  generate
    for (p = 0; p < NUM_TX; p++) begin : g_port
      logic bank_wr;
      logic single_set;
      logic periodic_pend_q;
      logic serving_single_q;
      logic gen_busy;
      logic gen_done;
      logic gen_start;
      logic start_single;
      logic start_periodic;
      logic pass_w;
      logic synced_w;
      csi2_tx_cal_pkg::link_in_t li;

      assign li = link_in[p];
      // a write reaches every bank whose enable is set
      assign bank_wr = wr_cal_ctrl && write_port_en[p];
      assign single_set = bank_wr && reg_wdata[csi2_tx_cal_pkg::SINGLE_BIT];

      // one-shot has priority; both only launch in a link idle period
      assign start_single = !gen_busy && li.link_idle &&
                            cal_ctrl_q[p].single && !serving_single_q;
      assign start_periodic = !gen_busy && li.link_idle && !start_single &&
                              periodic_pend_q && cal_ctrl_q[p].periodic;
      assign gen_start = start_single || start_periodic;

      // ********************************************************
      // control register bank
      // ********************************************************
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cal_ctrl_q[p] <= csi2_tx_cal_pkg::CAL_CTRL_RST;
        end else if (clk_en) begin
          if (bank_wr) begin
            cal_ctrl_q[p].cal_length_sel <= csi2_tx_cal_pkg::cal_len_t'(
              reg_wdata[csi2_tx_cal_pkg::LEN_MSB:csi2_tx_cal_pkg::LEN_LSB]);
            cal_ctrl_q[p].pass_mode <= reg_wdata[csi2_tx_cal_pkg::PASS_MODE_BIT];
            cal_ctrl_q[p].cal_pattern_invert <= reg_wdata[csi2_tx_cal_pkg::INV_BIT];
            cal_ctrl_q[p].periodic <= reg_wdata[csi2_tx_cal_pkg::PERIODIC_BIT];
          end
          // writing zero does not cancel a request; a new one wins over the clear
          if (single_set) begin
            cal_ctrl_q[p].single <= 1'b1;
          end else if (gen_done && serving_single_q) begin
            cal_ctrl_q[p].single <= 1'b0;
          end
        end
      end

      // ********************************************************
      // one-shot bookkeeping
      // ********************************************************
      // marks that the running sequence is the one-shot one
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          serving_single_q <= 1'b0;
        end else if (clk_en) begin
          if (start_single) begin
            serving_single_q <= 1'b1;
          end else if (gen_done) begin
            serving_single_q <= 1'b0;
          end
        end
      end

      // ********************************************************
      // periodic request after frame end
      // ********************************************************
      // a frame end arriving during launch is kept for the next sequence
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          periodic_pend_q <= 1'b0;
        end else if (clk_en) begin
          if (!cal_ctrl_q[p].periodic) begin
            periodic_pend_q <= 1'b0;
          end else if (li.frame_end_sent) begin
            periodic_pend_q <= 1'b1;
          end else if (start_periodic) begin
            periodic_pend_q <= 1'b0;
          end
        end
      end

      // ********************************************************
      // sequence generator and pass tracking
      // ********************************************************
      cal_pattern_gen u_gen (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(gen_start),
        .invert(cal_ctrl_q[p].cal_pattern_invert),
        .len(cal_ctrl_q[p].cal_length_sel),
        .busy(gen_busy),
        .cal_data(cal_data[p]),
        .done(gen_done)
      );

      pass_tracker #(
        .NUM_RX(NUM_RX)
      ) u_pass (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pass_mode(cal_ctrl_q[p].pass_mode),
        .rx_enable_mask(rx_enable_mask[p]),
        .rx_video_valid(rx_video_valid),
        .sync_enable(li.sync_enable),
        .sync_locked(li.sync_locked),
        .tx_error(li.tx_error),
        .pass_q(pass_w),
        .synced_q(synced_w)
      );

      assign cal_active[p] = gen_busy;
      assign tx_pass[p] = pass_w;
      assign tx_synced[p] = synced_w;

      // status image of this bank
      always_comb begin
        status_w[p] = csi2_tx_cal_pkg::STATUS_RST;
        status_w[p].port_num = read_port;
        status_w[p].synced = synced_w;
        status_w[p].pass = pass_w;
      end
    end
  endgenerate

  // ************************************************************
  // readback
  // ************************************************************
  logic [7:0] rd_mux;
  logic rd_idx;

  // with more than two ports only the first two can be read back
  assign rd_idx = read_port;

  always_comb begin
    rd_mux = csi2_tx_cal_pkg::UNMAPPED_RDATA;
    if (rd_hit) begin
      case (reg_addr)
        csi2_tx_cal_pkg::PORT_SEL_OFS: rd_mux = port_sel_q;
        csi2_tx_cal_pkg::CAL_CTRL_OFS: rd_mux = cal_ctrl_q[rd_idx];
        csi2_tx_cal_pkg::STATUS_OFS: rd_mux = status_w[rd_idx];
        default: rd_mux = csi2_tx_cal_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  // read data is captured on the strobe and held until the next read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule

/* File: dv/csi2_tx_cal_assertions.sv */
`timescale 1ns/1ps
module csi2_tx_cal_assertions #(
  parameter int NUM_TX = 2,
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_RX-1:0] rx_video_valid,
  input wire logic [NUM_TX-1:0][NUM_RX-1:0] rx_enable_mask,
  input wire csi2_tx_cal_pkg::link_in_t [NUM_TX-1:0] link_in,
  input wire logic [NUM_TX-1:0] cal_active,
  input wire logic [NUM_TX-1:0] cal_data,
  input wire logic [NUM_TX-1:0] tx_pass,
  input wire logic [NUM_TX-1:0] tx_synced
);
  // ****
  // port 0 run length, 17 bits so 32768 fits
  // ****
  logic [16:0] run_q;
  always_ff @(posedge clk) begin
    if (!rst_b || !cal_active[0]) begin
      run_q <= 17'h00000;
    end else begin
      run_q <= run_q + 17'h00001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_toggle0;
    cal_active[0] && $past(cal_active[0]) |-> cal_data[0] != $past(cal_data[0]);
  endproperty
  a_toggle0: assert property (p_toggle0) else $error("port 0 pattern not alternating");
  property p_toggle1;
    cal_active[1] && $past(cal_active[1]) |-> cal_data[1] != $past(cal_data[1]);
  endproperty
  a_toggle1: assert property (p_toggle1) else $error("port 1 pattern not alternating");
  property p_len0;
    $fell(cal_active[0]) |-> run_q inside {17'h00400, 17'h01000, 17'h04000, 17'h08000};
  endproperty
  a_len0: assert property (p_len0) else $error("port 0 sequence length wrong");
  property p_idle0;
    $rose(cal_active[0]) |-> $past(link_in[0].link_idle);
  endproperty
  a_idle0: assert property (p_idle0) else $error("sequence started on busy link");
  property p_synced0;
    $past(rst_b) |-> tx_synced[0] == $past(link_in[0].sync_enable && link_in[0].sync_locked);
  endproperty
  a_synced0: assert property (p_synced0) else $error("synced flag wrong");
  property p_none0;
    $past(rst_b) && $past((rx_enable_mask[0] & rx_video_valid) == '0) |-> !tx_pass[0];
  endproperty
  a_none0: assert property (p_none0) else $error("pass without valid video");
  property p_all0;
    $past(rst_b) && $past(rx_enable_mask[0] != '0 && (rx_enable_mask[0] & ~rx_video_valid) == '0
      && !(link_in[0].tx_error && !link_in[0].sync_enable)) |-> tx_pass[0];
  endproperty
  a_all0: assert property (p_all0) else $error("pass missing with all ports valid");
  property p_err0;
    $past(rst_b) && $past(link_in[0].tx_error && !link_in[0].sync_enable) |-> !tx_pass[0];
  endproperty
  a_err0: assert property (p_err0) else $error("pass held through error");
  property p_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  c_cal0: cover property ($rose(cal_active[0]));
  c_cal1: cover property ($rose(cal_active[1]));
  c_pass: cover property ($rose(tx_pass[0]));
endmodule
bind csi2_tx_skew_cal_and_status csi2_tx_cal_assertions #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX)) i_chk (
  .clk, .rst_b, .reg_rd, .reg_rdata, .rx_video_valid, .rx_enable_mask, .link_in,
  .cal_active, .cal_data, .tx_pass, .tx_synced);

/* File: dv/csi2_rx_model.sv */
`timescale 1ns/1ps
module csi2_rx_model (
  input wire logic clk,
  input wire logic [1:0] cal_active,
  input wire logic [1:0] cal_data
);
  // ****
  // receiver side: measures each calibration burst
  // ****
  int seqs[2] = '{0, 0};
  int len_q[2] = '{0, 0};
  int run[2] = '{0, 0};
  int bad[2] = '{0, 0};
  logic first_q[2];
  logic prev[2];
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (cal_active[p] === 1'b1) begin
        if (run[p] == 0) begin
          first_q[p] = cal_data[p];
        end else if (cal_data[p] === prev[p]) begin
          bad[p]++;
        end
        prev[p] = cal_data[p];
        run[p]++;
      end else if (run[p] != 0) begin
        seqs[p]++;
        len_q[p] = run[p];
        run[p] = 0;
      end
    end
  end
endmodule

/* File: dv/test_csi2_tx_skew_cal_and_status.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module test_csi2_tx_skew_cal_and_status;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] rx_video_valid = 4'h0;
  logic [1:0][3:0] rx_enable_mask = '0;
  csi2_tx_cal_pkg::link_in_t [1:0] link_in = '0;
  logic [1:0] cal_active;
  logic [1:0] cal_data;
  logic [1:0] tx_pass;
  logic [1:0] tx_synced;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int old;
  logic [31:0] seed;
  logic [7:0] d;
  logic [1:0] c;
  logic ep;
  logic es;
  logic [7:0] addrs[4] = '{8'h32, 8'h34, 8'h35, 8'h33};
  always #10 clk = ~clk;
  csi2_tx_skew_cal_and_status i_dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_video_valid(rx_video_valid), .rx_enable_mask(rx_enable_mask),
    .link_in(link_in), .cal_active(cal_active), .cal_data(cal_data), .tx_pass(tx_pass),
    .tx_synced(tx_synced));
  csi2_rx_model i_rx (.clk(clk), .cal_active(cal_active), .cal_data(cal_data));
  // ****
  // helpers
  // ****
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  function automatic int exp_len(input logic [1:0] k);
    return (k == 2'b11) ? 32768 : 1024 << (2 * k);
  endfunction
  function automatic logic exp_pass(input logic m, input logic [3:0] en, input logic [3:0] v,
                                    input logic se, input logic err);
    if (!se && err) return 1'b0;
    if (m) return (en != 4'h0) && ((en & v) == en);
    return (en & v) != 4'h0;
  endfunction
  task automatic wait_seq(input int p, input int o);
    int i = 0;
    while (i_rx.seqs[p] == o && i < 40000) begin
      @(posedge clk);
      i++;
    end
    #1 `CHK(i_rx.seqs[p], o + 1)
  endtask
  // a hang costs one mismatch, then the normal report
  always @(posedge clk) begin
    cyc++;
    if (cyc > 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    seed = $urandom(32'h6d7492d1);
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      `CHK(d, 8'h00)
    end
    $display("test reset values done");
    wr(8'h32, 8'h01);
    wr(8'h34, 8'h14);
    wr(8'h32, 8'h02);
    wr(8'h34, 8'h20);
    wr(8'h35, 8'hff);
    wr(8'h32, 8'h10);
    rd(8'h34);
    `CHK(d, 8'h20)
    rd(8'h35);
    `CHK(d, 8'h10)
    wr(8'h32, 8'h00);
    rd(8'h34);
    `CHK(d, 8'h14)
    wr(8'h32, 8'h03);
    wr(8'h34, 8'h08);
    rd(8'h34);
    `CHK(d, 8'h08)
    wr(8'h32, 8'h11);
    rd(8'h34);
    `CHK(d, 8'h08)
    $display("test banking done");
    wr(8'h32, 8'h01);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      link_in[0].link_idle = 1'b0;
      old = i_rx.seqs[0];
      wr(8'h34, {2'b00, c, 1'b0, c[0], 2'b10});
      repeat (20) @(posedge clk);
      #1 `CHK(cal_active[0], 1'b0)
      link_in[0].link_idle = 1'b1;
      wait_seq(0, old);
      `CHK(i_rx.len_q[0], exp_len(c))
      `CHK(i_rx.first_q[0], c[0])
      `CHK(i_rx.bad[0], 0)
      rd(8'h34);
      `CHK(d, {2'b00, c, 1'b0, c[0], 2'b00})
      repeat (10) @(posedge clk);
      #1 `CHK(i_rx.seqs[0], old + 1)
      $display("test one-shot code %0d done", k);
    end
    wr(8'h32, 8'h02);
    link_in[1].link_idle = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      old = i_rx.seqs[1];
      wr(8'h34, {7'h00, k[0]});
      link_in[1].frame_end_sent = 1'b1;
      @(posedge clk);
      #1 link_in[1].frame_end_sent = 1'b0;
      if (k == 1) begin
        wait_seq(1, old);
        `CHK(i_rx.len_q[1], 1024)
      end else begin
        repeat (30) @(posedge clk);
        #1 `CHK(i_rx.seqs[1], old)
      end
    end
    $display("test periodic done");
    wr(8'h32, 8'h03);
    for (int m = 0; m < 2; m++) begin
      wr(8'h34, {4'h0, m[0], 3'b000});
      repeat (25) begin
        rx_video_valid = 4'($urandom());
        rx_enable_mask = 8'($urandom());
        for (int p = 0; p < 2; p++) begin
          link_in[p].sync_enable = 1'($urandom());
          link_in[p].sync_locked = 1'($urandom());
          link_in[p].tx_error = 1'($urandom());
        end
        repeat (2) @(posedge clk);
        #1;
        for (int p = 0; p < 2; p++) begin
          ep = exp_pass(m[0], rx_enable_mask[p], rx_video_valid, link_in[p].sync_enable,
                        link_in[p].tx_error);
          es = link_in[p].sync_enable & link_in[p].sync_locked;
          `CHK(tx_pass[p], ep)
          `CHK(tx_synced[p], es)
        end
        rd(8'h35);
        // read select is port 0, so the status image is bank 0's
        es = link_in[0].sync_enable & link_in[0].sync_locked;
        ep = exp_pass(m[0], rx_enable_mask[0], rx_video_valid, link_in[0].sync_enable,
                      link_in[0].tx_error);
        `CHK(d, {6'h00, es, ep})
      end
    end
    $display("test pass and sync done");
    tally_and_finish();
  end
endmodule
